// >>> hw/debug_override_control.sv
// Debug override register bank and the memory-attribute steering it controls.
`timescale 1ns/100ps
`default_nettype none
`include "dbgovr_map.svh"
module debug_override_control (
    // Clock and reset
    input  wire logic                   clk,
    input  wire logic                   sys_rst,
    // Coprocessor instruction port
    input  wire logic [31:0]            instr,
    input  wire logic                   instrValid,
    input  wire logic [31:0]            wrData,
    output logic                        instrHit,
    output logic [31:0]                 rdData,
    // Memory system access start; the active settings are held while it is high
    input  wire logic                   accStart,
    // Cache clean operation
    output logic                        cleanWholeCache,
    // Translation buffer misses
    input  wire logic                   dMiss,
    input  wire logic                   iMiss,
    output logic                        dAbort,
    output logic                        iAbort,
    output logic                        dWalk,
    output logic                        iWalk,
    output logic [3:0]                  faultStatus,
    // Prefetch and clock gating
    input  wire logic                   coreInstrReq,
    input  wire logic                   specPrefetchReq,
    input  wire logic                   instrNonCacheable,
    output logic                        instrFetchReq,
    output logic                        gateEnable,
    // Data attribute steering
    input  wire logic                   mmuEnable,
    input  wire logic                   dcacheEnable,
    input  wire logic                   isStore,
    input  wire dbgovr_pkg::dbgovr_attr_e pageAttr,
    input  wire logic                   remapValid,
    input  wire dbgovr_pkg::dbgovr_attr_e remapAttr,
    output dbgovr_pkg::dbgovr_attr_e    dataAttr,
    // Debug and test address
    output dbgovr_pkg::dbgovr_word_t    testAddr
);
    dbgovr_if acc ();

    dbgovr_pkg::dbgovr_word_t ovr_q;
    dbgovr_pkg::dbgovr_word_t act_q;
    dbgovr_pkg::dbgovr_word_t addr_q;
    dbgovr_pkg::dbgovr_attr_e baseAttr;
    dbgovr_pkg::dbgovr_attr_e offAttr;
    logic [1:0]               missIn;
    logic [1:0]               abortSel;
    logic [1:0]               abortOut;
    logic [1:0]               walkOut;

    dbgovr_decode u_decode (
        .instr      (instr),
        .instrValid (instrValid),
        .acc        (acc)
    );

    assign instrHit = acc.hit;

    // Only the defined field bits are stored, so reserved positions read as zero.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ovr_q <= `DBGOVR_OVR_RESET;
        end else if (acc.wrOvr) begin
            ovr_q <= wrData & `DBGOVR_OVR_MASK;
        end
    end

    // The active copy is refreshed only between accesses, so an access in
    // flight keeps the settings it started with.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            act_q <= `DBGOVR_OVR_RESET;
        end else if (!accStart) begin
            act_q <= acc.wrOvr ? (wrData & `DBGOVR_OVR_MASK) : ovr_q;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            addr_q <= `DBGOVR_ADDR_RESET;
        end else if (acc.wrAddr) begin
            addr_q <= wrData;
        end
    end

    assign testAddr = addr_q;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rdData <= `DBGOVR_RD_RESET;
        end else if (acc.hit && !instr[`DBGOVR_DIR_BIT]) begin
            rdData <= acc.rdSel ? addr_q : ovr_q;
        end
    end

    assign cleanWholeCache = act_q[`DBGOVR_BIT_CLEAN_ALL];

    // Index 0 is the data side and index 1 the instruction side.
    assign missIn   = {iMiss, dMiss};
    assign abortSel = {act_q[`DBGOVR_BIT_ABORT_I], act_q[`DBGOVR_BIT_ABORT_D]};

    for (genvar side = 0; side < 2; side++) begin : g_miss
        assign abortOut[side] = missIn[side] && abortSel[side];
        assign walkOut[side]  = missIn[side] && !abortSel[side];
    end

    assign dAbort = abortOut[0];
    assign dWalk  = walkOut[0];
    assign iAbort = abortOut[1];
    assign iWalk  = walkOut[1];

    // Status holds the last aborted miss code until the next one.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            faultStatus <= `DBGOVR_FAULT_XLATE;
        end else if (dAbort || iAbort) begin
            faultStatus <= `DBGOVR_FAULT_XLATE;
        end
    end

    // Speculative requests for non-cacheable code pass only while prefetch is allowed.
    assign instrFetchReq = coreInstrReq
                        || (specPrefetchReq && !(instrNonCacheable && act_q[`DBGOVR_BIT_NO_PREF]));

    // Gating is a power matter only; nothing functional reads this enable.
    assign gateEnable = !act_q[`DBGOVR_BIT_NO_GATE];

    always_comb begin
        offAttr = (act_q[`DBGOVR_BIT_MMUOFF_WT] && dcacheEnable)
                ? dbgovr_pkg::DBGOVR_ATTR_WT : dbgovr_pkg::DBGOVR_ATTR_NONCACHEABLE_NONBUFFERABLE;
        if (!mmuEnable) begin
            baseAttr = remapValid ? remapAttr : offAttr;
        end else begin
            baseAttr = remapValid ? remapAttr : pageAttr;
        end
        dataAttr = baseAttr;
        if (isStore && act_q[`DBGOVR_BIT_FORCE_NB] && (baseAttr == dbgovr_pkg::DBGOVR_ATTR_NCB)) begin
            dataAttr = dbgovr_pkg::DBGOVR_ATTR_NONCACHEABLE_NONBUFFERABLE;
        end
    end
endmodule
`default_nettype wire

// >>> hw/dbgovr_map.svh
// Constant map of the debug override control block.
`ifndef DBGOVR_MAP_SVH
`define DBGOVR_MAP_SVH
`define DBGOVR_FIX_HI_MSB     27
`define DBGOVR_FIX_HI_LSB     24
`define DBGOVR_FIX_HI_VAL     4'he
`define DBGOVR_FIX_MID_MSB    11
`define DBGOVR_FIX_MID_LSB    8
`define DBGOVR_FIX_MID_VAL    4'hf
`define DBGOVR_FIX_BIT        4
`define DBGOVR_DIR_BIT        20
`define DBGOVR_OP1_MSB        23
`define DBGOVR_OP1_LSB        21
`define DBGOVR_PRI_MSB        19
`define DBGOVR_PRI_LSB        16
`define DBGOVR_OP2_MSB        7
`define DBGOVR_OP2_LSB        5
`define DBGOVR_SEC_MSB        3
`define DBGOVR_SEC_LSB        0
`define DBGOVR_PRI_DEBUG      4'hf
`define DBGOVR_SEC_OVERRIDE   4'h0
`define DBGOVR_SEC_ADDRESS    4'h1
`define DBGOVR_OP1_VAL        3'h0
`define DBGOVR_OP2_VAL        3'h0
`define DBGOVR_OVR_RESET      32'h0000_0000
`define DBGOVR_ADDR_RESET     32'h0000_0000
`define DBGOVR_RD_RESET       32'h0000_0000
`define DBGOVR_OVR_MASK       32'h000f_e000
`define DBGOVR_BIT_CLEAN_ALL  19
`define DBGOVR_BIT_ABORT_D    18
`define DBGOVR_BIT_ABORT_I    17
`define DBGOVR_BIT_NO_PREF    16
`define DBGOVR_BIT_NO_GATE    15
`define DBGOVR_BIT_FORCE_NB   14
`define DBGOVR_BIT_MMUOFF_WT  13
`define DBGOVR_FAULT_XLATE    4'h0
`endif

// >>> hw/dbgovr_pkg.sv
// Types shared by the debug override control block.
`default_nettype none
package dbgovr_pkg;
    typedef logic [31:0] dbgovr_word_t;
    typedef enum logic [1:0] {
        DBGOVR_ATTR_NONCACHEABLE_NONBUFFERABLE,
        DBGOVR_ATTR_NCB,
        DBGOVR_ATTR_WT,
        DBGOVR_ATTR_WB
    } dbgovr_attr_e;
endpackage
`default_nettype wire

// >>> hw/dbgovr_if.sv
// Decoded coprocessor access passed from the decoder to the register bank.
`timescale 1ns/100ps
`default_nettype none
interface dbgovr_if;
    logic                  wrOvr;
    logic                  wrAddr;
    logic                  rdSel;
    logic                  hit;
    modport dec (output wrOvr, output wrAddr, output rdSel, output hit);
    modport bank (input wrOvr, input wrAddr, input rdSel, input hit);
endinterface
`default_nettype wire

// >>> hw/dbgovr_decode.sv
// Decoder for system control coprocessor instructions aimed at this block.
`timescale 1ns/100ps
`default_nettype none
`include "dbgovr_map.svh"
module dbgovr_decode (
    // Instruction
    input  wire logic [31:0] instr,
    input  wire logic        instrValid,
    // Decoded access
    dbgovr_if.dec            acc
);
    logic                  fixedOk;
    logic                  mapOk;
    logic                  isWrite;

    assign fixedOk = (instr[`DBGOVR_FIX_HI_MSB:`DBGOVR_FIX_HI_LSB] == `DBGOVR_FIX_HI_VAL)
                  && (instr[`DBGOVR_FIX_MID_MSB:`DBGOVR_FIX_MID_LSB] == `DBGOVR_FIX_MID_VAL)
                  && instr[`DBGOVR_FIX_BIT];
    assign mapOk   = (instr[`DBGOVR_PRI_MSB:`DBGOVR_PRI_LSB] == `DBGOVR_PRI_DEBUG)
                  && (instr[`DBGOVR_OP1_MSB:`DBGOVR_OP1_LSB] == `DBGOVR_OP1_VAL)
                  && (instr[`DBGOVR_OP2_MSB:`DBGOVR_OP2_LSB] == `DBGOVR_OP2_VAL);
    assign isWrite = instr[`DBGOVR_DIR_BIT];

    assign acc.rdSel  = instr[`DBGOVR_SEC_MSB:`DBGOVR_SEC_LSB] == `DBGOVR_SEC_ADDRESS;
    assign acc.hit    = instrValid && fixedOk && mapOk
                     && ((instr[`DBGOVR_SEC_MSB:`DBGOVR_SEC_LSB] == `DBGOVR_SEC_OVERRIDE) || acc.rdSel);
    assign acc.wrOvr  = acc.hit && isWrite && !acc.rdSel;
    assign acc.wrAddr = acc.hit && isWrite && acc.rdSel;
endmodule
`default_nettype wire

// >>> testbench/dbgovr_sva.sv
// Assertions on the ports of the debug override block.
`timescale 1ns/100ps
`default_nettype none
module dbgovr_sva (
    // Watched ports
    input wire logic        clk,
    input wire logic        sys_rst,
    input wire logic [31:0] instr,
    input wire logic        instrValid,
    input wire logic        instrHit,
    input wire logic [31:0] wrData,
    input wire logic [31:0] rdData,
    input wire logic        accStart,
    input wire logic        cleanWholeCache,
    input wire logic [31:0] testAddr
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    wire logic take = instrValid && instrHit;
    a_hit_decode: assert property (instrHit == (instrValid && instr[27:21] == 7'h70
        && instr[19:16] == 4'hf && instr[11:4] == 8'hf1 && instr[3:1] == 3'h0)) else $error("bad decode");
    a_reset_zero: assert property (disable iff (1'b0) sys_rst |=> testAddr == 32'h0 && !cleanWholeCache)
        else $error("bad reset");
    a_addr_write: assert property (take && instr[20] && instr[0] |=> testAddr == $past(wrData))
        else $error("address lost");
    a_addr_hold: assert property (!(take && instr[20] && instr[0]) |=> $stable(testAddr))
        else $error("address moved");
    a_rsvd_zero: assert property (take && !instr[20] && !instr[0] |=> rdData[31:20] == 12'h0
        && rdData[12:0] == 13'h0) else $error("reserved set");
    a_addr_read: assert property (take && !instr[20] && instr[0] |=> rdData == $past(testAddr))
        else $error("bad address read");
    a_clean_set: assert property (take && instr[20] && !instr[0] && !accStart
        |=> cleanWholeCache == $past(wrData[19])) else $error("clean bit late");
    a_freeze_hold: assert property (accStart |=> $stable(cleanWholeCache)) else $error("frozen moved");
    c_ovr_write: cover property (take && instr[20] && !instr[0]);
    c_frozen_write: cover property (take && instr[20] && accStart);
    c_addr_read: cover property (take && !instr[20] && instr[0]);
endmodule
`default_nettype wire

// >>> testbench/dbgovr_core_model.sv
// Processor core model issuing coprocessor register transfers.
`timescale 1ns/100ps
`default_nettype none
module dbgovr_core_model (
    // Core side of the coprocessor port
    input  wire logic        clk,
    input  wire logic [31:0] rdData,
    output var logic [31:0]  instr = 32'h0,
    output var logic         instrValid = 1'b0,
    output var logic [31:0]  wrData = 32'h0
);
    // After each transfer the lines are inverted, so a stale word never passes for a new one.
    task automatic cpOp(input logic l, input logic [3:0] sec, input logic [31:0] d, output logic [31:0] q);
        @(negedge clk);
        instr = {8'hee, 3'h0, l, 4'hf, 4'h0, 4'hf, 3'h0, 1'b1, sec};
        wrData = (sec == 4'h0) ? (d & 32'h000f_e000) : d;
        instrValid = 1'b1;
        @(negedge clk);
        instrValid = 1'b0;
        {instr, wrData} = ~{instr, wrData};
        q = rdData;
    endtask
endmodule
`default_nettype wire

// >>> testbench/debug_override_control_test.sv
// Self-checking testbench for the debug override block.
`timescale 1ns/100ps
`default_nettype none
module debug_override_control_test;
    logic                     clk = 1'b0;
    logic                     sys_rst, accStart, dMiss, iMiss, coreInstrReq, specPrefetchReq, instrNonCacheable;
    logic                     mmuEnable, dcacheEnable, isStore, remapValid, instrValid, instrHit, cleanWholeCache;
    logic                     dAbort, iAbort, dWalk, iWalk, instrFetchReq, gateEnable;
    logic [3:0]               faultStatus;
    logic [31:0]              instr, wrData, rdData, testAddr, q, v;
    dbgovr_pkg::dbgovr_attr_e pageAttr, remapAttr, dataAttr;
    int                       failures = 0, totalChecks = 0;
    always #2 clk = ~clk;
    debug_override_control uut (.*);
    dbgovr_core_model core (.clk(clk), .rdData(rdData), .instr(instr), .instrValid(instrValid), .wrData(wrData));
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        totalChecks++;
        if (got !== exp) $display("[FAIL] %0t got %h want %h", $time, got, exp);
        failures += int'(got !== exp);
    endtask
    task automatic close_out();
        $display("checks %0d failures %0d", totalChecks, failures);
        if (failures == 0 && totalChecks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // Walks the access inputs with the override held, so every bit but specPrefetchReq and accStart is seen on and off.
    task automatic probe(input logic [31:0] ov);
        for (int c = 0; c < 4; c++) begin
            {mmuEnable, remapValid, dcacheEnable, isStore} = {c == 1, c == 2, c != 3, c == 2};
            {coreInstrReq, dMiss, iMiss, instrNonCacheable} = {c == 3, c[0], c[1], c != 2};
            #1 check(dataAttr, (c == 3) ? 2'h0 : (c == 0) ? {ov[13], 1'b0}
                : (c == 1) ? 2'h1 : {1'b0, !ov[14]});
            check({dAbort, dWalk, iAbort, iWalk, instrFetchReq}, {dMiss & ov[18], dMiss & !ov[18],
                iMiss & ov[17], iMiss & !ov[17], coreInstrReq | !(ov[16] & instrNonCacheable)});
            @(negedge clk);
        end
        check({cleanWholeCache, gateEnable, faultStatus}, {ov[19], !ov[15], 4'h0});
    endtask
    initial begin
        {sys_rst, specPrefetchReq, instrNonCacheable, accStart} = 4'he;
        pageAttr = dbgovr_pkg::DBGOVR_ATTR_NCB;
        remapAttr = dbgovr_pkg::DBGOVR_ATTR_NCB;
        {mmuEnable, remapValid, dcacheEnable, isStore, coreInstrReq, dMiss, iMiss} = 7'h0;
        repeat (3) @(negedge clk);
        sys_rst = 1'b0;
        for (int b = 13; b < 21; b++) begin
            v = (b == 20) ? 32'h000f_e000 : 32'h1 << b;
            core.cpOp(1'b1, 4'h0, v, q);
            core.cpOp(1'b0, 4'h0, 32'h0, q);
            check(q, v);
            probe(v);
        end
        $display("test override bits done");
        core.cpOp(1'b1, 4'h1, 32'ha5c3_0f1e, q);
        core.cpOp(1'b1, 4'h2, 32'h0, q);
        core.cpOp(1'b0, 4'h1, 32'h0, q);
        check(q, 32'ha5c3_0f1e);
        core.cpOp(1'b0, 4'h0, 32'h0, q);
        check(q, 32'h000f_e000);
        $display("test map done");
        accStart = 1'b1;
        core.cpOp(1'b1, 4'h0, 32'h0008_0000, q);
        check(gateEnable, 1'b0);
        check(cleanWholeCache, 1'b1);
        accStart = 1'b0;
        @(negedge clk);
        check(gateEnable, 1'b1);
        check(cleanWholeCache, 1'b1);
        sys_rst = 1'b1;
        @(negedge clk);
        sys_rst = 1'b0;
        check(testAddr, 32'h0);
        check(cleanWholeCache, 1'b0);
        core.cpOp(1'b0, 4'h0, 32'h0, q);
        check(q, 32'h0);
        $display("test freeze and reset done");
        close_out();
    end
    initial begin
        #20000 failures++;
        close_out();
    end
endmodule
bind debug_override_control dbgovr_sva chk (.*);
`default_nettype wire
